// ### spr_pkg.sv
// Purpose: Shared constants and types for flash self-programming, plus the page buffer.
// Assumes: One 200 MHz clock; software reaches the registers over APB.
// Notes:   The page buffer memory lives here beside the package, though it uses nothing from it.

`timescale 1ns/100ps
`default_nettype none

package spr_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS      = 5;
  localparam int NS_PER_US   = 1000;
  localparam int US_CYCLES   = NS_PER_US / CLK_NS;
  localparam int PROG_MIN_US = 3700;
  localparam int PROG_MAX_US = 4500;
  localparam int PROG_NOM_US = (PROG_MIN_US + PROG_MAX_US) / 2;
  localparam logic [2:0] LOAD_LAST  = 3'd2;  // Three-cycle window, last edge.
  localparam logic [2:0] STORE_LAST = 3'd3;  // Four-cycle window, last edge.

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_ZPTR   = 8'h04;
  localparam logic [7:0] ADDR_WDATA  = 8'h08;
  localparam logic [7:0] ADDR_STORE  = 8'h0C;
  localparam logic [7:0] ADDR_LOAD   = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam int BIT_EN = 0;
  localparam int BIT_IE = 7;
  localparam logic [6:0] CODE_ERASE = 7'h03;
  localparam logic [6:0] CODE_BUFLD = 7'h01;
  localparam logic [6:0] CODE_PWRT  = 7'h05;
  localparam logic [6:0] CODE_LOCK  = 7'h09;
  localparam logic [6:0] CODE_RWWRE = 7'h11;
  localparam logic [6:0] CODE_SIG   = 7'h21;

  // ----------------------------------------------------------------
  // Readback selectors and values
  // ----------------------------------------------------------------
  localparam logic [15:0] Z_FUSE_LO  = 16'h0000;
  localparam logic [15:0] Z_LOCK     = 16'h0001;
  localparam logic [15:0] Z_FUSE_EXT = 16'h0002;
  localparam logic [15:0] Z_FUSE_HI  = 16'h0003;
  localparam logic [15:0] Z_SIG1     = 16'h0000;
  localparam logic [15:0] Z_CAL      = 16'h0001;
  localparam logic [15:0] Z_SIG2     = 16'h0002;
  localparam logic [15:0] Z_SIG3     = 16'h0004;
  localparam logic [7:0]  ALL_ONES   = 8'hFF;
  localparam logic [1:0]  LOCK_PAD   = 2'h3;
  localparam logic [15:0] BUF_ERASED = 16'hFFFF;
  localparam logic [15:0] NO_READ_WHILE_WRITE_SECTION_START_WORD = 16'h3800;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_IDLE, ARM_ERASE, ARM_BUFLD, ARM_PWRT, ARM_LOCK, ARM_SIG, ARM_RWWRE
  } spr_cmd_t;

  typedef enum logic [1:0] {OP_IDLE, OP_STREAM, OP_WAIT} spr_op_t;

  typedef struct packed {
    logic        erase;
    logic        we;
    logic        lock;
    logic [15:0] addr;
    logic [15:0] data;
  } spr_flash_prog_t;

endpackage : spr_pkg

// ------------------------------------------------------------------
// Page buffer: one write port, one read port with registered data
// ------------------------------------------------------------------
module spr_page_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 64,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock.
  input  wire logic             clk,
  // Write port.
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // Read port; data follow the request by one cycle.
  input  wire logic             re,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Storage has no reset; word validity is tracked by the controller.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read keeps the output timing clean.
  always_ff @(posedge clk) begin
    if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule : spr_page_buf

`default_nettype wire

// ### spr_selfprog_ctrl.sv
// Purpose: Flash self-programming control with fuse, lock and signature readback.
// Assumes: pclk at 200 MHz; APB slave with one wait state; flash read data valid
//          in the same cycle as flash_rd_en.
// Notes:   por_n resets only the programming engine, rww_busy and cpu_halt so a system reset cannot
//          cut a running flash write short.
//
// The implementer's own choices: the address map and register access over APB.

`timescale 1ns/100ps
`default_nettype none

module spr_selfprog_ctrl #(
  parameter int          PAGE_WORDS = 64,
  parameter logic [15:0] NO_READ_WHILE_WRITE_SECTION_START = spr_pkg::NO_READ_WHILE_WRITE_SECTION_START_WORD,
  parameter int          PROG_US    = spr_pkg::PROG_NOM_US
) (
  // Clock and resets.
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     por_n,
  // APB slave.
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Nonvolatile sources.
  input  wire logic                     eeprom_write_busy,
  input  wire logic [7:0]               fuse_low_byte,
  input  wire logic [7:0]               fuse_high_byte,
  input  wire logic [7:0]               extended_fuse_byte,
  input  wire logic [5:0]               lock_bits_nv,
  input  wire logic [7:0]               sig_byte1,
  input  wire logic [7:0]               sig_byte2,
  input  wire logic [7:0]               sig_byte3,
  input  wire logic [7:0]               osc_cal_byte,
  // Flash array.
  output logic                          flash_rd_en,
  output logic      [15:0]              flash_rd_addr,
  input  wire logic [7:0]               flash_rd_data,
  output spr_pkg::spr_flash_prog_t      flash_prog,
  // Core status.
  output logic                          rww_busy,
  output logic                          cpu_halt,
  output logic                          selfprog_irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int PB = $clog2(PAGE_WORDS);

  spr_pkg::spr_cmd_t cmd_state;
  spr_pkg::spr_cmd_t cmd_decoded;
  spr_pkg::spr_op_t  op_state;
  logic [2:0]            win_cnt;
  logic [15:0]           zptr;
  logic [15:0]           wdata;
  logic                  ie_reg;
  logic                  wait_reg;
  logic                  load_flash_reg;
  logic [7:0]            load_byte_reg;
  logic [7:0]            special;
  logic [7:0]            ctrl_rd;
  logic [31:0]           rd_value;
  logic [PAGE_WORDS-1:0] buf_valid;
  logic                  vld_d;
  logic                  eeprom_prev;
  logic [15:0]           buf_rdata;
  logic [PB:0]           op_cnt;
  logic [PB-1:0]         cnt_m1;
  logic [14:0]           op_page;
  logic [14:0]           page_base;
  logic                  op_kind_pw;
  logic                  pwrite_done;
  logic [7:0]            us_div;
  logic [31:0]           op_us;
  logic setup, acc_done, addr_hit, wr_ctrl, wr_store, load_take;
  logic op_idle, sp_enable, cmd_ok, load_mode, load_late, store_late;
  logic store_hit, buf_we, buf_re, reenable, start_erase, start_pwrite;
  logic start_lock, rww_addr, target_rww;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Writes act on the completing edge; a load acts at its setup edge so
  // that it lands inside the short readback window.
  assign setup     = psel & ~penable;
  assign acc_done  = psel & penable & pready;
  assign wr_ctrl   = acc_done & pwrite & (paddr == spr_pkg::ADDR_CTRL);
  assign wr_store  = acc_done & pwrite & (paddr == spr_pkg::ADDR_STORE);
  assign load_take = setup & ~pwrite & (paddr == spr_pkg::ADDR_LOAD);
  assign addr_hit  = paddr inside {spr_pkg::ADDR_CTRL, spr_pkg::ADDR_ZPTR,
                                   spr_pkg::ADDR_WDATA, spr_pkg::ADDR_STORE,
                                   spr_pkg::ADDR_LOAD, spr_pkg::ADDR_STATUS};

  // ----------------------------------------------------------------
  // Command acceptance and timed windows
  // ----------------------------------------------------------------
  // selfprog_enable is the union of an armed command and a running operation.
  assign op_idle   = (op_state == spr_pkg::OP_IDLE);
  assign sp_enable = (cmd_state != spr_pkg::CMD_IDLE) | ~op_idle;
  assign cmd_ok    = wr_ctrl & pwdata[spr_pkg::BIT_EN] & ~eeprom_write_busy
                   & (cmd_state == spr_pkg::CMD_IDLE) & op_idle;
  assign load_mode = (cmd_state == spr_pkg::ARM_LOCK) | (cmd_state == spr_pkg::ARM_SIG);
  assign load_late  = load_mode & (win_cnt == spr_pkg::LOAD_LAST);
  assign store_late = ~load_mode & (win_cnt == spr_pkg::STORE_LAST);
  assign store_hit  = wr_store & (cmd_state != spr_pkg::CMD_IDLE);

  // Bit 7 of the code is a don't-care, so only the low seven bits decode.
  always_comb begin
    cmd_decoded = spr_pkg::CMD_IDLE;
    case (pwdata[6:0])
      spr_pkg::CODE_ERASE: cmd_decoded = spr_pkg::ARM_ERASE;
      spr_pkg::CODE_BUFLD: cmd_decoded = spr_pkg::ARM_BUFLD;
      spr_pkg::CODE_PWRT:  cmd_decoded = spr_pkg::ARM_PWRT;
      spr_pkg::CODE_LOCK:  cmd_decoded = spr_pkg::ARM_LOCK;
      spr_pkg::CODE_SIG:   cmd_decoded = spr_pkg::ARM_SIG;
      spr_pkg::CODE_RWWRE: cmd_decoded = spr_pkg::ARM_RWWRE;
      default:             cmd_decoded = spr_pkg::CMD_IDLE;
    endcase
  end

  // Armed command state; it drops on its action or when its window runs out.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_state <= spr_pkg::CMD_IDLE;
      win_cnt   <= 3'd0;
    end else if (cmd_ok) begin
      cmd_state <= cmd_decoded;
      win_cnt   <= 3'd0;
    end else if (cmd_state != spr_pkg::CMD_IDLE) begin
      win_cnt <= win_cnt + 3'd1;
      if ((load_take & load_mode) | store_hit | load_late | store_late) begin
        cmd_state <= spr_pkg::CMD_IDLE;
      end
    end
  end

  // Software-visible pointer, data word and interrupt enable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zptr   <= 16'h0000;
      wdata  <= 16'h0000;
      ie_reg <= 1'b0;
    end else begin
      if (acc_done & pwrite & (paddr == spr_pkg::ADDR_ZPTR)) begin
        zptr <= pwdata[15:0];
      end
      if (acc_done & pwrite & (paddr == spr_pkg::ADDR_WDATA)) begin
        wdata <= pwdata[15:0];
      end
      if (wr_ctrl) begin
        ie_reg <= pwdata[spr_pkg::BIT_IE];
      end
    end
  end

  // ----------------------------------------------------------------
  // Readback of fuses, lock bits and signature row
  // ----------------------------------------------------------------
  // Stored bits are already zero when programmed, so they pass unchanged.
  always_comb begin
    special = spr_pkg::ALL_ONES;
    if (cmd_state == spr_pkg::ARM_SIG) begin
      case (zptr)
        spr_pkg::Z_SIG1: special = sig_byte1;
        spr_pkg::Z_CAL:  special = osc_cal_byte;
        spr_pkg::Z_SIG2: special = sig_byte2;
        spr_pkg::Z_SIG3: special = sig_byte3;
        default:         special = spr_pkg::ALL_ONES;
      endcase
    end else begin
      case (zptr)
        spr_pkg::Z_LOCK:     special = {spr_pkg::LOCK_PAD, lock_bits_nv};
        spr_pkg::Z_FUSE_LO:  special = fuse_low_byte;
        spr_pkg::Z_FUSE_HI:  special = fuse_high_byte;
        spr_pkg::Z_FUSE_EXT: special = extended_fuse_byte;
        default:             special = spr_pkg::ALL_ONES;
      endcase
    end
  end

  // A normal load into the busy READ_WHILE_WRITE_SECTION section reads all ones instead of stale data.
  assign rww_addr = zptr[15:1] < NO_READ_WHILE_WRITE_SECTION_START[14:0];

  // Load capture: special bytes are latched at the setup edge; ordinary
  // loads strobe the array, which answers in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_rd_en    <= 1'b0;
      flash_rd_addr  <= 16'h0000;
      load_flash_reg <= 1'b0;
      load_byte_reg  <= spr_pkg::ALL_ONES;
    end else begin
      flash_rd_en <= 1'b0;
      if (load_take) begin
        flash_rd_addr  <= zptr;
        load_flash_reg <= ~load_mode & ~(rww_busy & rww_addr);
        flash_rd_en    <= ~load_mode & ~(rww_busy & rww_addr);
        if (load_mode & ~(eeprom_write_busy & (cmd_state == spr_pkg::ARM_LOCK))) begin
          load_byte_reg <= special;
        end else begin
          load_byte_reg <= spr_pkg::ALL_ONES;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  assign ctrl_rd = {ie_reg, rww_busy,
                    cmd_state == spr_pkg::ARM_SIG, cmd_state == spr_pkg::ARM_RWWRE,
                    cmd_state == spr_pkg::ARM_LOCK, cmd_state == spr_pkg::ARM_PWRT,
                    cmd_state == spr_pkg::ARM_ERASE, sp_enable};

  always_comb begin
    rd_value = 32'h0000_0000;
    case (paddr)
      spr_pkg::ADDR_CTRL:   rd_value = {24'h00_0000, ctrl_rd};
      spr_pkg::ADDR_ZPTR:   rd_value = {16'h0000, zptr};
      spr_pkg::ADDR_WDATA:  rd_value = {16'h0000, wdata};
      spr_pkg::ADDR_LOAD:   rd_value = {24'h00_0000,
                                        load_flash_reg ? flash_rd_data : load_byte_reg};
      spr_pkg::ADDR_STATUS: rd_value = {28'h000_0000, cpu_halt, ~op_idle,
                                        rww_busy, eeprom_write_busy};
      default:              rd_value = 32'h0000_0000;
    endcase
  end

  // One wait state for every access keeps the load path simple and uniform.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg <= 1'b0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0000_0000;
    end else if (setup) begin
      wait_reg <= 1'b1;
      pready   <= 1'b0;
    end else if (wait_reg) begin
      wait_reg <= 1'b0;
      pready   <= 1'b1;
      pslverr  <= ~addr_hit;
      prdata   <= pwrite ? 32'h0000_0000 : rd_value;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Completion interrupt level follows selfprog_enable being clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      selfprog_irq <= 1'b0;
    end else begin
      selfprog_irq <= ie_reg & ~sp_enable;
    end
  end

  // ----------------------------------------------------------------
  // Store actions and page buffer
  // ----------------------------------------------------------------
  assign buf_we       = store_hit & (cmd_state == spr_pkg::ARM_BUFLD);
  assign reenable     = store_hit & (cmd_state == spr_pkg::ARM_RWWRE);
  assign start_erase  = store_hit & (cmd_state == spr_pkg::ARM_ERASE);
  assign start_pwrite = store_hit & (cmd_state == spr_pkg::ARM_PWRT);
  assign start_lock   = store_hit & (cmd_state == spr_pkg::ARM_LOCK);
  assign page_base    = {zptr[15:PB+1], {PB{1'b0}}};
  assign buf_re       = (op_state == spr_pkg::OP_STREAM) & (op_cnt < (PB+1)'(PAGE_WORDS));
  assign cnt_m1       = op_cnt[PB-1:0] - {{(PB-1){1'b0}}, 1'b1};

  spr_page_buf #(
    .WIDTH (16),
    .DEPTH (PAGE_WORDS),
    .AW    (PB)
  ) u_buf (
    .clk   (pclk),
    .we    (buf_we),
    .waddr (zptr[PB:1]),
    .wdata (wdata),
    .re    (buf_re),
    .raddr (op_cnt[PB-1:0]),
    .rdata (buf_rdata)
  );

  // Word validity: erased by re-enable, page write, reset or an EEPROM
  // write starting; a load in the same cycle still counts.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_valid   <= '0;
      eeprom_prev <= 1'b0;
      vld_d       <= 1'b0;
    end else begin
      eeprom_prev <= eeprom_write_busy;
      vld_d       <= buf_valid[op_cnt[PB-1:0]];
      if (reenable | pwrite_done | (eeprom_write_busy & ~eeprom_prev)) begin
        buf_valid <= '0;
      end
      if (buf_we) begin
        buf_valid[zptr[PB:1]] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Programming engine on the power-on reset only
  // ----------------------------------------------------------------
  // The timer counts microseconds from a divider pulse of the system clock,
  // which itself is derived from the calibrated oscillator.
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      op_state    <= spr_pkg::OP_IDLE;
      op_cnt      <= '0;
      op_page     <= 15'h0000;
      op_kind_pw  <= 1'b0;
      us_div      <= 8'h00;
      op_us       <= 32'h0000_0000;
      pwrite_done <= 1'b0;
      flash_prog  <= '0;
    end else begin
      pwrite_done      <= 1'b0;
      flash_prog.erase <= 1'b0;
      flash_prog.we    <= 1'b0;
      flash_prog.lock  <= 1'b0;
      case (op_state)
        spr_pkg::OP_IDLE: begin
          op_cnt     <= '0;
          us_div     <= 8'h00;
          op_us      <= 32'h0000_0000;
          op_page    <= page_base;
          op_kind_pw <= start_pwrite;
          if (start_erase) begin
            flash_prog.erase <= 1'b1;
            flash_prog.addr  <= {1'b0, page_base};
            op_state         <= spr_pkg::OP_WAIT;
          end else if (start_pwrite) begin
            op_state <= spr_pkg::OP_STREAM;
          end else if (start_lock) begin
            flash_prog.lock <= 1'b1;
            flash_prog.data <= {8'h00, spr_pkg::LOCK_PAD, wdata[5:0]};
            op_state        <= spr_pkg::OP_WAIT;
          end
        end
        spr_pkg::OP_STREAM: begin
          op_cnt <= op_cnt + 1'b1;
          if (op_cnt != '0) begin
            flash_prog.we   <= 1'b1;
            flash_prog.addr <= {1'b0, op_page | 15'(cnt_m1)};
            flash_prog.data <= vld_d ? buf_rdata : spr_pkg::BUF_ERASED;
          end
          if (op_cnt == (PB+1)'(PAGE_WORDS)) begin
            op_state <= spr_pkg::OP_WAIT;
          end
        end
        spr_pkg::OP_WAIT: begin
          if (us_div == 8'(spr_pkg::US_CYCLES - 1)) begin
            us_div <= 8'h00;
            op_us  <= op_us + 32'd1;
          end else begin
            us_div <= us_div + 8'h01;
          end
          if (op_us == 32'(PROG_US)) begin
            op_state    <= spr_pkg::OP_IDLE;
            pwrite_done <= op_kind_pw;
          end
        end
        default: op_state <= spr_pkg::OP_IDLE;
      endcase
    end
  end

  // READ_WHILE_WRITE_SECTION busy and core halt also survive a system reset with the operation.
  assign target_rww = page_base < NO_READ_WHILE_WRITE_SECTION_START[14:0];

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      rww_busy <= 1'b0;
      cpu_halt <= 1'b0;
    end else begin
      if (reenable) begin
        rww_busy <= 1'b0;
      end
      if ((start_erase | start_pwrite) & target_rww) begin
        rww_busy <= 1'b1;
      end
      if (op_idle & (start_erase | start_pwrite)) begin
        cpu_halt <= ~target_rww;
      end else if (op_idle) begin
        cpu_halt <= 1'b0;
      end
    end
  end

endmodule : spr_selfprog_ctrl

`default_nettype wire

// ### spr_selfprog_ctrl_monitor.sv
// Purpose: Port checker for the self-programming controller.
// Assumes: One clock; presetn and por_n active low.
// Notes:   Bound to every controller instance below.
`timescale 1ns/100ps
`default_nettype none
module spr_ctrl_monitor #(
  parameter int          PROG_US    = 2,
  parameter logic [15:0] NO_READ_WHILE_WRITE_SECTION_START = 16'h3800
) (
  input wire logic                     pclk, presetn, por_n, psel, penable, pwrite, pready,
  input wire logic [7:0]               paddr,
  input wire logic                     flash_rd_en, rww_busy,
  input wire logic [15:0]              flash_rd_addr,
  input wire spr_pkg::spr_flash_prog_t flash_prog
);
  wire st = psel && penable && pready && pwrite && paddr == spr_pkg::ADDR_STORE;
  int gap_q;
  // Cycles since the last erase or lock strobe; saturates so it never wraps.
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) gap_q <= 1000000;
    else if (flash_prog.erase || flash_prog.lock) gap_q <= 0;
    else if (gap_q < 1000000) gap_q <= gap_q + 1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !por_n);
  pready_pulse_a: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready is not a single access pulse");
  load_read_a: assert property (flash_rd_en |-> $past(psel) && !$past(penable)
    && !$past(pwrite) && $past(paddr) == spr_pkg::ADDR_LOAD)
    else $error("flash read without a load request");
  rd_pulse_a: assert property ($rose(flash_rd_en) |=> !flash_rd_en)
    else $error("flash read strobe longer than one cycle");
  rww_fetch_a: assert property (flash_rd_en && rww_busy |-> flash_rd_addr[15:1] >= NO_READ_WHILE_WRITE_SECTION_START)
    else $error("busy section read during programming");
  rww_hold_a: assert property ($fell(rww_busy) |-> $past(st) || $past(st, 2))
    else $error("rww_busy cleared without a store");
  erase_store_a: assert property (flash_prog.erase || flash_prog.lock |-> $past(st))
    else $error("timed operation without a store");
  prog_pulse_a: assert property (flash_prog.erase |=> !flash_prog.erase [*8])
    else $error("erase strobe repeated");
  prog_gap_a: assert property (flash_prog.erase |-> gap_q >= PROG_US * spr_pkg::US_CYCLES)
    else $error("operation started before the previous one ended");
  cover property (flash_prog.erase);
  cover property ($fell(rww_busy));
  cover property (flash_rd_en && rww_busy);
  cover property (flash_prog.we);
endmodule : spr_ctrl_monitor
bind spr_selfprog_ctrl spr_ctrl_monitor #(.PROG_US(PROG_US), .NO_READ_WHILE_WRITE_SECTION_START(NO_READ_WHILE_WRITE_SECTION_START)) i_mon (
  .pclk, .presetn, .por_n, .psel, .penable, .pwrite, .pready, .paddr, .flash_rd_en,
  .rww_busy, .flash_rd_addr, .flash_prog);
`default_nettype wire

// ### spr_flash_model.sv
// Purpose: Flash array read port model.
// Assumes: Data are needed in the cycle of the read strobe.
// Notes:   Byte value is the low address byte xor 5A.
`timescale 1ns/100ps
`default_nettype none
module spr_flash_model (
  input wire logic        flash_rd_en,
  input wire logic [15:0] flash_rd_addr,
  output logic     [7:0]  flash_rd_data
);
  // Off-strobe the bus shows the inverse, so a late capture is caught.
  assign flash_rd_data = {8{!flash_rd_en}} ^ flash_rd_addr[7:0] ^ 8'h5A;
endmodule : spr_flash_model
`default_nettype wire

// ### spr_selfprog_ctrl_tb_top.sv
// Purpose: Self-checking bench for the self-programming controller.
// Assumes: APB master in tasks; reads checked from a queue.
// Notes:   PROG_US is 2 so one operation lasts 400 cycles.
`timescale 1ns/100ps
`default_nettype none
module spr_selfprog_ctrl_tb_top;
  logic pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0, ee = 0;
  logic [7:0] paddr = 0, fl = 0, fh = 0, fe = 0, s1 = 0, s2 = 0, s3 = 0, cal = 0, frd;
  logic [31:0] pwdata = 0, prdata;
  logic [5:0] lk = 0;
  logic [15:0] fra;
  logic pready, pslverr, fre, rww_busy;
  spr_pkg::spr_flash_prog_t flash_prog;
  logic [8:0] exp_q[$];
  logic [15:0] wd[2];
  logic [31:0] exp_w;
  logic irq;
  int we_n = 0;
  int error_cnt = 0, checks = 0, cyc = 0;
  always #2.5 pclk = ~pclk;
  spr_selfprog_ctrl #(.PROG_US(2)) i_dut (.pclk, .presetn, .por_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .eeprom_write_busy(ee),
    .fuse_low_byte(fl), .fuse_high_byte(fh), .extended_fuse_byte(fe), .lock_bits_nv(lk),
    .sig_byte1(s1), .sig_byte2(s2), .sig_byte3(s3), .osc_cal_byte(cal), .flash_rd_en(fre),
    .flash_rd_addr(fra), .flash_rd_data(frd), .flash_prog, .rww_busy, .cpu_halt(),
    .selfprog_irq(irq));
  spr_flash_model i_flash (.flash_rd_en(fre), .flash_rd_addr(fra), .flash_rd_data(frd));
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", name, exp, seen);
    end
  endtask : check
  // Each completed read is compared with the oldest note; program strobes with the page.
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      check("prdata", {23'h0, exp_q[0]}, {23'h0, pslverr, prdata[7:0]});
      void'(exp_q.pop_front());
    end
    if (flash_prog.we) begin
      exp_w = {16'h0040 + 16'(we_n), (we_n < 2) ? wd[we_n] : 16'hFFFF};
      check("prog_word", exp_w, {flash_prog.addr, flash_prog.data});
      we_n++;
    end
    if (flash_prog.lock) check("lock_word", 32'h0000_00C3, {16'h0, flash_prog.data});
    if (++cyc == 20000) begin
      error_cnt++;
      finish_test;
    end
  end
  // Without the idle cycle psel stays up and the next setup follows at once.
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d,
                     input bit idle = 1'b1);
    if (psel !== 1'b1) psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    penable <= 0;
    if (idle) begin
      psel <= 0;
      @(posedge pclk);
    end
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    exp_q.push_back(e);
    apb(0, a, 16'h0000);
  endtask : rd
  task automatic cmd(input logic [6:0] c, input logic [15:0] z, input logic [7:0] e);
    apb(1, 8'h04, z);
    apb(1, 8'h00, {9'h000, c});
    rd(8'h10, {1'b0, e});
  endtask : cmd
  initial begin
    void'($urandom(54581));
    repeat (20) @(posedge pclk);
    presetn <= 1;
    por_n <= 1;
    for (int i = 0; i < 2; i++) begin
      {fl, fh, fe, s1} <= $urandom;
      {s2, s3, cal, lk} <= 30'($urandom);
      @(posedge pclk);
      cmd(7'h09, 16'h0000, fl);
      cmd(7'h09, 16'h0001, {2'b11, lk});
      cmd(7'h09, 16'h0002, fe);
      cmd(7'h09, 16'h0003, fh);
      cmd(7'h21, 16'h0000, s1);
      cmd(7'h21, 16'h0001, cal);
      cmd(7'h21, 16'h0002, s2);
      cmd(7'h21, 16'h0004, s3);
      cmd(7'h21, 16'h0003, 8'hFF);
    end
    $display("test readback done");
    apb(1, 8'h04, 16'h0100);
    apb(1, 8'h00, 16'h0009);
    repeat (4) @(posedge pclk);
    rd(8'h10, 8'h5A);
    apb(1, 8'h00, 16'h0021);
    repeat (4) @(posedge pclk);
    rd(8'h10, 8'h5A);
    apb(1, 8'h04, 16'h0000);
    fl <= 8'h12;
    apb(1, 8'h00, 16'h0009);
    ee <= 1;
    rd(8'h10, 8'hFF);
    apb(1, 8'h00, 16'h0003);
    rd(8'h00, 8'h00);
    ee <= 0;
    $display("test timeout and blocking done");
    apb(1, 8'h04, 16'h0080);
    apb(1, 8'h00, 16'h0003);
    apb(1, 8'h0C, 16'h0000);
    rd(8'h14, 8'h06);
    rd(8'h10, 8'hFF);
    apb(1, 8'h04, 16'h7000);
    rd(8'h10, 8'h5A);
    presetn <= 0;
    @(posedge pclk) presetn <= 1;
    @(posedge pclk);
    rd(8'h14, 8'h06);
    repeat (400) @(posedge pclk);
    rd(8'h14, 8'h02);
    apb(1, 8'h00, 16'h0011);
    apb(1, 8'h0C, 16'h0000);
    rd(8'h14, 8'h00);
    rd(8'h1C, 9'h100);
    $display("test erase done");
    for (int i = 0; i < 2; i++) begin
      wd[i] = 16'($urandom);
      apb(1, 8'h04, 16'h0080 + 16'(2 * i));
      apb(1, 8'h08, wd[i]);
      apb(1, 8'h00, 16'h0001);
      apb(1, 8'h0C, 16'h0000);
    end
    apb(1, 8'h04, 16'h0080);
    apb(1, 8'h00, 16'h0005);
    apb(1, 8'h0C, 16'h0000);
    rd(8'h14, 8'h06);
    apb(1, 8'h00, 16'h0080);
    check("irq_busy", 32'h0, {31'h0, irq});
    repeat (80) @(posedge pclk);
    check("we_cnt", 32'd64, we_n);
    repeat (400) @(posedge pclk);
    check("irq_done", 32'h1, {31'h0, irq});
    $display("test page write done");
    apb(1, 8'h08, 16'h0003);
    apb(1, 8'h00, 16'h0009, 1'b0);
    apb(1, 8'h0C, 16'h0000);
    rd(8'h00, 8'h41);
    $display("test lock write done");
    finish_test;
  end
endmodule : spr_selfprog_ctrl_tb_top
`default_nettype wire
